// file: inc/efg_consts.svh
`ifndef EFG_CONSTS_SVH
`define EFG_CONSTS_SVH
// Notes on behaviour
// - receive buffer is 4,096 byte dual-port memory
// - only error-free received frames reach user side
// - receive overflow drops whole frame, pulses flag
// - transmit buffer is 4096 byte dual-port memory
// - transmit frame leaves only once fully stored
// - mac stalls with ready; data held until taken
// - full transmit memory lowers user-side ready
// - frameless full transmit memory: flag, accept, drop
// - loopback through exchanger, or generator into transmit
// - exchanger holds both address fields before forwarding
// - exchanger swaps address fields only when enabled
// - valid and last delayed exactly like data
// - generator mode flushes receive frames, drives exchanger
// - addresses and size limits are design parameters
// - sizes step up from minimum to maximum, wrap
// - type/length from size, payload counts down to 0x1
// - generator rate held slightly below line rate at 10M; at 100M and 1G one byte per clock cycle

// buffer address width, 4096 bytes each
`define EFG_FIFO_AW 12
// address fields and type/length field
`define EFG_ADDR_BYTES 6
`define EFG_HDR_BYTES 12
`define EFG_HEAD_BYTES 14
// generator defaults
`define EFG_DEST_ADDR 48'h0A1B2C3D4E5F
`define EFG_SRC_ADDR 48'h025A5A5A5A01
`define EFG_MIN_SIZE 16'h002E
`define EFG_MAX_SIZE 16'h05DC
// speed switch codes
`define EFG_SPEED_10M 2'h0
`define EFG_SPEED_100M 2'h1
`define EFG_SPEED_1G 2'h2
// timing: clock period and byte time per line rate, in ns
`define EFG_CLK_NS 100
`define EFG_BYTE_NS_10M 800
`define EFG_BYTE_NS_100M 80
`define EFG_BYTE_NS_1G 8
// least time rounds up to whole cycles
`define EFG_CYC(ns) (((ns) + `EFG_CLK_NS - 1) / `EFG_CLK_NS)
// preamble plus gap, plus one byte of slack below line rate
`define EFG_GAP_BYTES 21
`endif

// file: inc/efg_pkg.sv
package efg_pkg;

typedef struct packed {
    logic [7:0] data;
    logic last;
} efg_beat_t;

typedef struct packed {
    logic gen_en;
    logic swap_en;
    logic [1:0] speed;
} efg_switch_t;

typedef enum logic [1:0] {
    SW_HOLD = 2'h0,
    SW_EMIT = 2'h1,
    SW_PASS = 2'h2
} efg_swap_st_t;

typedef enum logic [1:0] {
    GN_IDLE = 2'h0,
    GN_HDR = 2'h1,
    GN_PAY = 2'h2,
    GN_GAP = 2'h3
} efg_gen_st_t;

endpackage

// file: rtl/efg_dpram.sv
`timescale 1ns/1ps
module efg_dpram #(
    parameter int DW = 9,
    parameter int AW = 12
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

// file: rtl/efg_frame_path.sv
`timescale 1ns/1ps
`include "efg_consts.svh"
module efg_frame_path #(
    parameter int AW = `EFG_FIFO_AW,
    parameter logic [47:0] DEST_ADDR = `EFG_DEST_ADDR,
    parameter logic [47:0] SRC_ADDR = `EFG_SRC_ADDR,
    parameter logic [15:0] MIN_SIZE = `EFG_MIN_SIZE,
    parameter logic [15:0] MAX_SIZE = `EFG_MAX_SIZE
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // mac receive stream
    input wire logic mac_rx_valid,
    input wire efg_pkg::efg_beat_t mac_rx_beat,
    input wire logic mac_rx_bad,
    // mac transmit stream
    output logic mac_tx_valid,
    output efg_pkg::efg_beat_t mac_tx_beat,
    input wire logic mac_tx_ready,
    // board switches
    input wire efg_pkg::efg_switch_t switch_pins,
    // status
    output logic rx_dropped,
    output logic tx_dropped
);
    import efg_pkg::*;

    // switch synchroniser
    efg_switch_t sw_meta_q;
    efg_switch_t sw_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            sw_meta_q <= '0;
            sw_q <= '0;
        end else begin
            sw_meta_q <= switch_pins;
            sw_q <= sw_meta_q;
        end
    end

    // buffer ports: index 0 receive, index 1 transmit
    logic f_in_valid [2];
    efg_beat_t f_in_beat [2];
    logic f_in_bad [2];
    logic f_in_ready [2];
    logic f_out_valid [2];
    efg_beat_t f_out_beat [2];
    logic f_out_ready [2];
    logic f_drop [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_fifo
            logic [AW-1:0] wr_q;
            logic [AW-1:0] cmt_q;
            logic [AW-1:0] rd_q;
            logic [AW-1:0] wr_next;
            logic drop_q;
            logic fresh_q;
            logic pulse_q;
            logic full;
            logic have_frame;
            logic take_in;
            logic take_out;
            logic ovf;
            logic we;
            efg_beat_t rdata;

            assign wr_next = AW'(wr_q + 1'b1);
            assign full = wr_next == rd_q;
            assign have_frame = cmt_q != rd_q;
            // receive side cannot stall the mac
            assign f_in_ready[g] = (g == 0) ? 1'b1
                                 : !(full && have_frame);
            assign take_in = f_in_valid[g] && f_in_ready[g];
            assign ovf = take_in && full && !drop_q;
            assign we = take_in && !full && !drop_q;

            always_ff @(posedge clk) begin
                if (srst) begin
                    wr_q <= '0;
                    cmt_q <= '0;
                    drop_q <= 1'b0;
                    pulse_q <= 1'b0;
                end else begin
                    pulse_q <= ovf;
                    if (take_in) begin
                        if (drop_q || ovf) begin
                            // swallow the rest, then rewind
                            if (f_in_beat[g].last) begin
                                wr_q <= cmt_q;
                                drop_q <= 1'b0;
                            end else begin
                                drop_q <= 1'b1;
                            end
                        end else if (f_in_beat[g].last) begin
                            if (f_in_bad[g]) begin
                                wr_q <= cmt_q;
                            end else begin
                                wr_q <= wr_next;
                                cmt_q <= wr_next;
                            end
                        end else begin
                            wr_q <= wr_next;
                        end
                    end
                end
            end

            // read side: only committed frames are visible
            assign take_out = f_out_valid[g] && f_out_ready[g];
            assign f_out_valid[g] = have_frame && fresh_q;
            assign f_out_beat[g] = rdata;
            assign f_drop[g] = pulse_q;

            always_ff @(posedge clk) begin
                if (srst) begin
                    rd_q <= '0;
                    fresh_q <= 1'b0;
                end else begin
                    // data stands until taken
                    fresh_q <= have_frame && !take_out;
                    if (take_out) begin
                        rd_q <= AW'(rd_q + 1'b1);
                    end
                end
            end

            efg_dpram #(
                .DW($bits(efg_beat_t)),
                .AW(AW)
            ) u_mem (
                .clk(clk),
                .we(we),
                .waddr(wr_q),
                .wdata(f_in_beat[g]),
                .raddr(rd_q),
                .rdata(rdata)
            );
        end
    endgenerate

    // mac connections
    assign f_in_valid[0] = mac_rx_valid;
    assign f_in_beat[0] = mac_rx_beat;
    assign f_in_bad[0] = mac_rx_bad;
    assign f_out_ready[1] = mac_tx_ready;
    assign mac_tx_valid = f_out_valid[1];
    assign mac_tx_beat = f_out_beat[1];
    assign rx_dropped = f_drop[0];
    assign tx_dropped = f_drop[1];

    // source selection
    logic mode_gen_q;
    logic mux_mid_q;
    logic rx_mid_q;
    logic src_valid;
    efg_beat_t src_beat;
    logic src_take;
    logic rx_take;
    logic sw_in_ready;
    logic gv_q;
    efg_beat_t gbeat_q;
    logic g_ready;

    assign src_valid = mode_gen_q ? gv_q : f_out_valid[0];
    assign src_beat = mode_gen_q ? gbeat_q : f_out_beat[0];
    // generator mode flushes receive frames
    assign f_out_ready[0] = mode_gen_q ? 1'b1 : sw_in_ready;
    assign g_ready = mode_gen_q && sw_in_ready;
    assign src_take = src_valid && sw_in_ready;
    assign rx_take = f_out_valid[0] && f_out_ready[0];

    // mode changes only between frames
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_gen_q <= 1'b0;
            mux_mid_q <= 1'b0;
            rx_mid_q <= 1'b0;
        end else begin
            if (src_take) begin
                mux_mid_q <= !src_beat.last;
            end
            if (rx_take) begin
                rx_mid_q <= !f_out_beat[0].last;
            end
            if (!mux_mid_q && !rx_mid_q && !src_take && !rx_take) begin
                mode_gen_q <= sw_q.gen_en;
            end
        end
    end

    // generator
    function automatic logic [15:0] byte_cycles(input logic [1:0] spd);
        logic [15:0] c;
        c = 16'h0001;
        unique case (spd)
            `EFG_SPEED_10M: c = 16'(`EFG_CYC(`EFG_BYTE_NS_10M));
            `EFG_SPEED_100M: c = 16'(`EFG_CYC(`EFG_BYTE_NS_100M));
            `EFG_SPEED_1G: c = 16'(`EFG_CYC(`EFG_BYTE_NS_1G));
            default: c = 16'(`EFG_CYC(`EFG_BYTE_NS_1G));
        endcase
        return c;
    endfunction

    function automatic logic [7:0] hdr_byte(
        input logic [3:0] idx,
        input logic [15:0] size
    );
        logic [7:0] b;
        b = 8'h00;
        if (idx < 4'h6) begin
            b = DEST_ADDR[8 * (5 - int'(idx)) +: 8];
        end else if (idx < 4'hC) begin
            b = SRC_ADDR[8 * (11 - int'(idx)) +: 8];
        end else if (idx == 4'hC) begin
            b = size[15:8];
        end else begin
            b = size[7:0];
        end
        return b;
    endfunction

    efg_gen_st_t gst_q;
    logic [15:0] size_q;
    logic [15:0] cnt_q;
    logic [3:0] hix_q;
    logic [15:0] spc_q;
    logic [15:0] bcyc;
    logic emit;
    logic [7:0] gen_data;
    logic gen_last;

    assign bcyc = byte_cycles(sw_q.speed);
    assign emit = (!gv_q || g_ready) && spc_q == 16'h0000
                  && (gst_q == GN_HDR || gst_q == GN_PAY);
    assign gen_data = (gst_q == GN_HDR) ? hdr_byte(hix_q, size_q)
                                        : cnt_q[7:0];
    assign gen_last = gst_q == GN_PAY && cnt_q == 16'h0001;

    always_ff @(posedge clk) begin
        if (srst || !mode_gen_q) begin
            gst_q <= GN_IDLE;
            size_q <= MIN_SIZE;
            cnt_q <= 16'h0000;
            hix_q <= 4'h0;
        end else begin
            unique case (gst_q)
                GN_IDLE: begin
                    gst_q <= GN_HDR;
                    hix_q <= 4'h0;
                end
                GN_HDR: begin
                    if (emit) begin
                        hix_q <= hix_q + 4'h1;
                        if (hix_q == 4'(`EFG_HEAD_BYTES - 1)) begin
                            gst_q <= GN_PAY;
                            cnt_q <= size_q;
                        end
                    end
                end
                GN_PAY: begin
                    if (emit) begin
                        cnt_q <= cnt_q - 16'h0001;
                        if (gen_last) begin
                            gst_q <= GN_GAP;
                            size_q <= (size_q >= MAX_SIZE) ? MIN_SIZE
                                      : size_q + 16'h0001;
                        end
                    end
                end
                GN_GAP: begin
                    if (spc_q == 16'h0000) begin
                        gst_q <= GN_HDR;
                        hix_q <= 4'h0;
                    end
                end
            endcase
        end
    end

    // pacing: one byte time per byte, line gap after the frame
    always_ff @(posedge clk) begin
        if (srst || !mode_gen_q) begin
            spc_q <= 16'h0000;
        end else if (emit) begin
            spc_q <= gen_last
                ? 16'(bcyc * 16'(`EFG_GAP_BYTES + 1) - 16'h0001)
                : bcyc - 16'h0001;
        end else if (spc_q != 16'h0000) begin
            spc_q <= spc_q - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !mode_gen_q) begin
            gv_q <= 1'b0;
            gbeat_q <= '0;
        end else if (emit) begin
            gv_q <= 1'b1;
            gbeat_q.data <= gen_data;
            gbeat_q.last <= gen_last;
        end else if (g_ready) begin
            gv_q <= 1'b0;
        end
    end

    // address exchanger
    function automatic logic [3:0] swap_idx(
        input logic [3:0] idx,
        input logic sw
    );
        logic [3:0] r;
        r = idx;
        if (sw) begin
            r = (idx < 4'h6) ? idx + 4'h6 : idx - 4'h6;
        end
        return r;
    endfunction

    efg_swap_st_t sst_q;
    logic [7:0] hb_q [`EFG_HDR_BYTES];
    logic [3:0] hcnt_q;
    logic [3:0] eix_q;
    logic [3:0] hend_q;
    logic short_q;
    logic swap_q;
    logic ov_q;
    efg_beat_t ob_q;
    logic oslot;

    assign oslot = !ov_q || f_in_ready[1];
    // nothing goes out while the address fields are gathered
    assign sw_in_ready = (sst_q == SW_HOLD)
                         || (sst_q == SW_PASS && oslot);
    assign f_in_valid[1] = ov_q;
    assign f_in_beat[1] = ob_q;
    assign f_in_bad[1] = 1'b0;

    always_ff @(posedge clk) begin
        if (srst) begin
            sst_q <= SW_HOLD;
            hcnt_q <= 4'h0;
            eix_q <= 4'h0;
            hend_q <= 4'h0;
            short_q <= 1'b0;
            swap_q <= 1'b0;
        end else begin
            unique case (sst_q)
                SW_HOLD: begin
                    if (src_take) begin
                        hb_q[hcnt_q] <= src_beat.data;
                        hcnt_q <= hcnt_q + 4'h1;
                        if (src_beat.last
                            || hcnt_q == 4'(`EFG_HDR_BYTES - 1)) begin
                            sst_q <= SW_EMIT;
                            eix_q <= 4'h0;
                            hend_q <= hcnt_q;
                            short_q <= src_beat.last;
                            swap_q <= sw_q.swap_en
                                && hcnt_q == 4'(`EFG_HDR_BYTES - 1);
                        end
                    end
                end
                SW_EMIT: begin
                    if (oslot) begin
                        eix_q <= eix_q + 4'h1;
                        if (eix_q == hend_q) begin
                            sst_q <= short_q ? SW_HOLD : SW_PASS;
                            hcnt_q <= 4'h0;
                        end
                    end
                end
                SW_PASS: begin
                    if (src_take && src_beat.last) begin
                        sst_q <= SW_HOLD;
                    end
                end
                default: begin
                    sst_q <= SW_HOLD;
                end
            endcase
        end
    end

    // output stage carries data, valid and last together
    always_ff @(posedge clk) begin
        if (srst) begin
            ov_q <= 1'b0;
            ob_q <= '0;
        end else if (sst_q == SW_EMIT && oslot) begin
            ov_q <= 1'b1;
            ob_q.data <= hb_q[swap_idx(eix_q, swap_q)];
            ob_q.last <= short_q && eix_q == hend_q;
        end else if (sst_q == SW_PASS && src_take) begin
            ov_q <= 1'b1;
            ob_q <= src_beat;
        end else if (f_in_ready[1]) begin
            ov_q <= 1'b0;
        end
    end
endmodule

// file: sim/efg_frame_path_props.sv
`timescale 1ns/1ps
module efg_frame_path_props #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // mac receive stream
    input wire logic mac_rx_valid,
    input wire efg_pkg::efg_beat_t mac_rx_beat,
    input wire logic mac_rx_bad,
    // mac transmit stream
    input wire logic mac_tx_valid,
    input wire efg_pkg::efg_beat_t mac_tx_beat,
    input wire logic mac_tx_ready,
    // switches and status
    input wire efg_pkg::efg_switch_t switch_pins,
    input wire logic rx_dropped,
    input wire logic tx_dropped
);
    import efg_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    AST_TX_VALID_HOLD: assert property (
        mac_tx_valid && !mac_tx_ready |=> mac_tx_valid)
        else $error("tx valid fell before take");
    AST_TX_BEAT_HOLD: assert property (
        mac_tx_valid && !mac_tx_ready |=> $stable(mac_tx_beat))
        else $error("tx beat changed before take");
    AST_TX_BURST: assert property (
        mac_tx_valid && mac_tx_ready && !mac_tx_beat.last |=> ##1 mac_tx_valid)
        else $error("stored frame underran");
    AST_TX_ONE_BEAT: assert property (
        mac_tx_valid && mac_tx_ready |=> !mac_tx_valid)
        else $error("tx valid stayed after take");
    AST_RX_DROP_PULSE: assert property (
        rx_dropped |=> !rx_dropped)
        else $error("rx drop flag longer than one cycle");
    AST_RX_DROP_CAUSE: assert property (
        rx_dropped |-> $past(mac_rx_valid))
        else $error("rx drop without receive beat");
    AST_TX_DROP_PULSE: assert property (
        tx_dropped |=> !tx_dropped)
        else $error("tx drop flag longer than one cycle");
    AST_RESET_QUIET: assert property (
        $fell(srst) |-> !mac_tx_valid && !rx_dropped && !tx_dropped)
        else $error("outputs active out of reset");
endmodule

// file: sim/efg_frame_path_test.sv
`timescale 1ns/1ps
module efg_frame_path_test;
    import efg_pkg::*;
    localparam logic [47:0] G_DEST = 48'h112233445566;
    localparam logic [47:0] G_SRC = 48'hA0B0C0D0E0F0;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic mac_rx_valid = 1'b0;
    efg_beat_t mac_rx_beat = '0;
    logic mac_rx_bad = 1'b0;
    logic mac_tx_valid;
    efg_beat_t mac_tx_beat;
    logic mac_tx_ready;
    efg_switch_t switch_pins = efg_switch_t'(4'h2);
    logic rx_dropped;
    logic tx_dropped;
    logic stall = 1'b0;
    logic slow = 1'b0;
    int err_total = 0;
    int total_checks = 0;
    int rxd_cnt = 0;
    int txd_cnt = 0;
    efg_beat_t exp[$];
    logic tmo = 1'b0;
    logic big_txv;
    logic big_txd;
    int big_drops = 0;
    int big_valids = 0;
    always #50 clk = ~clk;
    efg_frame_path #(.DEST_ADDR(G_DEST), .SRC_ADDR(G_SRC),
        .MIN_SIZE(16'h0002), .MAX_SIZE(16'h0003)) dut (
        .clk(clk), .srst(srst), .mac_rx_valid(mac_rx_valid),
        .mac_rx_beat(mac_rx_beat), .mac_rx_bad(mac_rx_bad),
        .mac_tx_valid(mac_tx_valid), .mac_tx_beat(mac_tx_beat),
        .mac_tx_ready(mac_tx_ready), .switch_pins(switch_pins),
        .rx_dropped(rx_dropped), .tx_dropped(tx_dropped));
    efg_mac_model mac (.clk(clk), .srst(srst), .stall(stall), .slow(slow),
        .mac_tx_valid(mac_tx_valid), .mac_tx_beat(mac_tx_beat),
        .mac_tx_ready(mac_tx_ready));
    // generated frames too long for the transmit buffer, mac stalled
    efg_frame_path #(.MIN_SIZE(16'h1004), .MAX_SIZE(16'h1004)) dut_big (
        .clk(clk), .srst(srst), .mac_rx_valid(mac_rx_valid),
        .mac_rx_beat(mac_rx_beat), .mac_rx_bad(mac_rx_bad),
        .mac_tx_valid(big_txv), .mac_tx_beat(),
        .mac_tx_ready(1'h0), .switch_pins(efg_switch_t'(4'hA)),
        .rx_dropped(), .tx_dropped(big_txd));
    always @(posedge clk) begin
        if (rx_dropped === 1'b1) rxd_cnt <= rxd_cnt + 1;
        if (tx_dropped === 1'b1) txd_cnt <= txd_cnt + 1;
        if (big_txd === 1'b1) big_drops <= big_drops + 1;
        if (!srst && big_txv !== 1'b0) big_valids <= big_valids + 1;
    end
    function automatic logic [7:0] fb(int k, int i);
        return 8'(k * 37 + i * 5 + 1);
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic send(int k, int len, logic bad);
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            mac_rx_valid <= 1'b1;
            mac_rx_beat <= '{data: fb(k, i), last: i == len - 1};
            mac_rx_bad <= bad && (i == len - 1);
        end
        @(posedge clk);
        mac_rx_valid <= 1'b0;
        mac_rx_bad <= 1'b0;
    endtask
    task automatic push(int k, int len, logic swap);
        int j;
        for (int i = 0; i < len; i++) begin
            j = (swap && len > 11 && i < 12) ? (i < 6 ? i + 6 : i - 6) : i;
            exp.push_back('{data: fb(k, j), last: i == len - 1});
        end
    endtask
    task automatic gpush(logic [15:0] size);
        for (int i = 0; i < 6; i++) exp.push_back('{G_DEST[47-8*i -: 8], 1'b0});
        for (int i = 0; i < 6; i++) exp.push_back('{G_SRC[47-8*i -: 8], 1'b0});
        exp.push_back('{size[15:8], 1'b0});
        exp.push_back('{size[7:0], 1'b0});
        for (int p = size; p >= 1; p--) exp.push_back('{8'(p), p == 1});
    endtask
    // waits for the expected beats; tail > 0 also proves nothing extra
    task automatic drain(int tail);
        int n;
        n = 0;
        while (!tmo && mac.got.size() < exp.size() && n < 40000) begin
            @(negedge clk);
            n++;
        end
        // a hang counts once, later drains skip their waits
        if (n == 40000) begin
            err_total++;
            tmo = 1'b1;
        end
        repeat (tail) @(negedge clk);
        if (tail > 0) chk(16'(mac.got.size()), 16'(exp.size()));
        foreach (exp[i]) chk(16'(mac.got[i]), 16'(exp[i]));
        mac.got.delete();
        exp.delete();
        @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        send(1, 20, 1'b0);
        push(1, 20, 1'b0);
        send(2, 30, 1'b1);
        send(3, 8, 1'b0);
        push(3, 8, 1'b0);
        drain(100);
        switch_pins <= efg_switch_t'(4'h6);
        repeat (4) @(posedge clk);
        slow <= 1'b1;
        send(4, 64, 1'b0);
        push(4, 64, 1'b1);
        send(5, 10, 1'b0);
        push(5, 10, 1'b0);
        send(15, 12, 1'b0);
        push(15, 12, 1'b1);
        drain(100);
        slow <= 1'b0;
        stall <= 1'b1;
        for (int k = 6; k < 11; k++) begin
            send(k, 1000, 1'b0);
            push(k, 1000, 1'b1);
        end
        repeat (2000) @(posedge clk);
        chk(16'(mac.got.size()), 16'h0000);
        stall <= 1'b0;
        drain(100);
        send(11, 4000, 1'b0);
        push(11, 4000, 1'b1);
        send(12, 4100, 1'b0);
        send(13, 16, 1'b0);
        push(13, 16, 1'b1);
        drain(100);
        chk(16'(rxd_cnt), 16'h0001);
        switch_pins <= efg_switch_t'(4'hA);
        repeat (4) @(posedge clk);
        send(14, 20, 1'b0);
        gpush(16'h0002);
        gpush(16'h0003);
        gpush(16'h0002);
        drain(0);
        chk(16'(txd_cnt), 16'h0000);
        chk(16'(big_drops > 0), 16'h0001);
        chk(16'(big_valids), 16'h0000);
        end_sim();
    end
endmodule
bind efg_frame_path efg_frame_path_props #(.AW(AW)) u_props (
    .clk(clk), .srst(srst), .mac_rx_valid(mac_rx_valid),
    .mac_rx_beat(mac_rx_beat), .mac_rx_bad(mac_rx_bad),
    .mac_tx_valid(mac_tx_valid), .mac_tx_beat(mac_tx_beat),
    .mac_tx_ready(mac_tx_ready), .switch_pins(switch_pins),
    .rx_dropped(rx_dropped), .tx_dropped(tx_dropped));

// file: sim/efg_mac_model.sv
`timescale 1ns/1ps
module efg_mac_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pacing control
    input wire logic stall,
    input wire logic slow,
    // transmit stream from the device
    input wire logic mac_tx_valid,
    input wire efg_pkg::efg_beat_t mac_tx_beat,
    output logic mac_tx_ready
);
    import efg_pkg::*;
    efg_beat_t got[$];
    logic tick_q = 1'b0;
    initial mac_tx_ready = 1'b0;
    always @(posedge clk) begin
        tick_q <= !tick_q;
        mac_tx_ready <= !srst && !stall && (!slow || tick_q);
        if (!srst && mac_tx_valid && mac_tx_ready) begin
            got.push_back(mac_tx_beat);
        end
    end
endmodule
